// File: logic/ttsc_top.sv
// transmit symbol timing: modulation width, bursts, guard wait, stop bits
`timescale 1ns/1ps
`include "ttsc_params.svh"
module ttsc_top #(
    parameter int WAIT_W = 11
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic miller_mode,
    input wire logic type_b_mode,
    input wire logic pulse_start,
    input wire logic bit_end,
    input wire logic bit_tick,
    input wire logic half_bit_tick,
    input wire logic burst_req,
    input wire logic burst_symbol,
    input wire logic burst_level,
    input wire logic tx_req,
    input wire logic tx_end,
    input wire logic rx_end,
    input wire logic [7:0] wait_count_lower,
    output logic mod_pulse,
    output logic burst_active,
    output logic burst_out,
    output logic stop_bit_en,
    output logic [2:0] guard_count,
    output logic tx_start,
    output logic wait_elapsed
);
    logic [7:0] tx_mod_pulse_width_reg;
    logic [7:0] tx_burst_length_reg;
    logic [7:0] tx_wait_control_reg;
    logic [15:0] carrier_acc_reg;
    logic [15:0] carrier_sum;
    logic carrier_tick;
    logic [8:0] pulse_cnt_reg;
    logic [8:0] burst_cnt_reg;
    logic tx_pending_reg;
    logic wait_event;
    logic [2:0] stop_code;

    if (WAIT_W != 3 + 8) begin : g_bad_wait
        $error("ttsc_top: WAIT_W must be 11, upper three plus lower eight bits");
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_mod_pulse_width_reg <= `TTSC_RST_MOD_WIDTH;
            tx_burst_length_reg <= `TTSC_RST_BURST_LEN;
            tx_wait_control_reg <= `TTSC_RST_WAIT_CTRL;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                `TTSC_ADDR_MOD_WIDTH: tx_mod_pulse_width_reg <= reg_wdata;
                `TTSC_ADDR_BURST_LEN: tx_burst_length_reg <= reg_wdata & `TTSC_BURST_MASK;
                `TTSC_ADDR_WAIT_CTRL: tx_wait_control_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            case (reg_addr)
                `TTSC_ADDR_MOD_WIDTH: reg_rdata <= tx_mod_pulse_width_reg;
                `TTSC_ADDR_BURST_LEN: reg_rdata <= tx_burst_length_reg;
                `TTSC_ADDR_WAIT_CTRL: reg_rdata <= tx_wait_control_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // carrier rate enable
    // ----------------------------------------------------------------
    // fractional divider: average rate is exact, single ticks jitter by one cycle
    assign carrier_sum = carrier_acc_reg + `TTSC_CARRIER_KHZ;
    assign carrier_tick = (carrier_sum >= `TTSC_CLK_KHZ);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            carrier_acc_reg <= 16'h0000;
        end
        else
        begin
            carrier_acc_reg <= carrier_tick ? carrier_sum - `TTSC_CLK_KHZ : carrier_sum;
        end
    end

    // ----------------------------------------------------------------
    // modulation pulse
    // ----------------------------------------------------------------
    // same path for data, start and stop symbols
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mod_pulse <= 1'b0;
            pulse_cnt_reg <= 9'h000;
        end
        else if (pulse_start && miller_mode)
        begin
            mod_pulse <= 1'b1;
            pulse_cnt_reg <= {1'b0, tx_mod_pulse_width_reg} + 9'h001;
        end
        else if (bit_end || !miller_mode)
        begin
            mod_pulse <= 1'b0;
        end
        else if (mod_pulse && carrier_tick)
        begin
            pulse_cnt_reg <= pulse_cnt_reg - 9'h001;
            if (pulse_cnt_reg == 9'h001)
            begin
                mod_pulse <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // burst
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            burst_active <= 1'b0;
            burst_out <= 1'b0;
            burst_cnt_reg <= 9'h000;
        end
        else if (burst_req)
        begin
            burst_active <= 1'b1;
            burst_out <= burst_level;
            burst_cnt_reg <= burst_symbol
                ? ttsc_pkg::ttsc_burst_bits(tx_burst_length_reg[`TTSC_SYM1_MSB:`TTSC_SYM1_LSB])
                : ttsc_pkg::ttsc_burst_bits(tx_burst_length_reg[`TTSC_SYM0_MSB:`TTSC_SYM0_LSB]);
        end
        else if (burst_active && bit_tick)
        begin
            burst_cnt_reg <= burst_cnt_reg - 9'h001;
            if (burst_cnt_reg == 9'h001)
            begin
                burst_active <= 1'b0;
                burst_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // stop bits and extra guard time
    // ----------------------------------------------------------------
    assign stop_code = tx_wait_control_reg[`TTSC_STOP_MSB:`TTSC_STOP_LSB];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stop_bit_en <= 1'b0;
            guard_count <= 3'h0;
        end
        else
        begin
            stop_bit_en <= type_b_mode && stop_code != 3'h0;
            guard_count <= (type_b_mode && stop_code != 3'h0) ? stop_code - 3'h1 : 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // guard wait and transmit gate
    // ----------------------------------------------------------------
    assign wait_event = tx_wait_control_reg[`TTSC_WAIT_START_BIT] ? rx_end : tx_end;

    ttsc_wait_timer #(
        .WAIT_W(WAIT_W)
    ) u_wait (
        .clk(clk),
        .reset(reset),
        .start(wait_event),
        .unit_sel(tx_wait_control_reg[`TTSC_WAIT_UNIT_BIT]),
        .count({tx_wait_control_reg[`TTSC_WAIT_HI_MSB:`TTSC_WAIT_HI_LSB],
            wait_count_lower}),
        .carrier_tick(carrier_tick),
        .half_bit_tick(half_bit_tick),
        .elapsed(wait_elapsed)
    );

    // a request arriving with the start it is cleared by stays pending
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_pending_reg <= 1'b0;
            tx_start <= 1'b0;
        end
        else
        begin
            tx_start <= tx_pending_reg && wait_elapsed && !tx_start && !wait_event;
            if (tx_req)
            begin
                tx_pending_reg <= 1'b1;
            end
            else if (tx_start)
            begin
                tx_pending_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [8:0] obs_pulse_ticks;
    logic [8:0] obs_pulse_target;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            obs_pulse_ticks <= 9'h000;
            obs_pulse_target <= 9'h000;
        end
        else if (pulse_start && miller_mode)
        begin
            obs_pulse_ticks <= 9'h000;
            obs_pulse_target <= {1'b0, tx_mod_pulse_width_reg} + 9'h001;
        end
        else if (mod_pulse && carrier_tick)
        begin
            obs_pulse_ticks <= obs_pulse_ticks + 9'h001;
        end
    end

    property p_pulse_len;
        @(posedge clk) disable iff (reset)
        $fell(mod_pulse) && $past(!bit_end && miller_mode) |-> obs_pulse_ticks == obs_pulse_target;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("modulation pulse length differs from width plus one");

    property p_pulse_cut;
        @(posedge clk) disable iff (reset)
        bit_end && !pulse_start |=> !mod_pulse;
    endproperty
    a_pulse_cut: assert property (p_pulse_cut)
        else $error("modulation pulse ran past the end of the bit");

    property p_pulse_rise;
        @(posedge clk) disable iff (reset)
        $rose(mod_pulse) |-> $past(pulse_start && miller_mode);
    endproperty
    a_pulse_rise: assert property (p_pulse_rise)
        else $error("modulation pulse started outside miller mode or pulse position");

    property p_pulse_start;
        @(posedge clk) disable iff (reset)
        pulse_start && miller_mode |=> mod_pulse;
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("modulation pulse did not start at the pulse position");

    // checks the decode at the request, whatever the phase of the bit grid
    property p_burst_zero;
        @(posedge clk) disable iff (reset)
        burst_req && !burst_symbol
            && tx_burst_length_reg[`TTSC_SYM0_MSB:`TTSC_SYM0_LSB] == 3'h0
            |=> burst_active && burst_cnt_reg == 9'h008;
    endproperty
    a_burst_zero: assert property (p_burst_zero)
        else $error("symbol zero burst code zero is not eight bits");

    property p_stop_type_b;
        @(posedge clk) disable iff (reset)
        !type_b_mode |=> !stop_bit_en && guard_count == 3'h0;
    endproperty
    a_stop_type_b: assert property (p_stop_type_b)
        else $error("stop bits set outside type b");

    property p_stop_code;
        @(posedge clk) disable iff (reset)
        type_b_mode && stop_code == 3'h7 |=> stop_bit_en && guard_count == 3'h6;
    endproperty
    a_stop_code: assert property (p_stop_code)
        else $error("stop code seven did not give six guard times");

    property p_tx_gate;
        @(posedge clk) disable iff (reset)
        tx_start |-> $past(wait_elapsed && tx_pending_reg);
    endproperty
    a_tx_gate: assert property (p_tx_gate)
        else $error("transmission started before the wait elapsed");

    property p_wait_source;
        @(posedge clk) disable iff (reset)
        wait_event
            && {tx_wait_control_reg[`TTSC_WAIT_HI_MSB:`TTSC_WAIT_HI_LSB], wait_count_lower}
            != 11'h000 |=> !wait_elapsed;
    endproperty
    a_wait_source: assert property (p_wait_source)
        else $error("selected start event did not restart the wait");
endmodule

// File: logic/ttsc_wait_timer.sv
// guard wait timer counted in carrier units or half bit periods
`timescale 1ns/1ps
`include "ttsc_params.svh"
module ttsc_wait_timer #(
    parameter int WAIT_W = 11
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic unit_sel,
    input wire logic [WAIT_W-1:0] count,
    input wire logic carrier_tick,
    input wire logic half_bit_tick,
    output logic elapsed
);
    ttsc_pkg::ttsc_wait_state_t state_reg;
    logic [WAIT_W-1:0] cnt_reg;
    logic [3:0] pre_reg;
    logic unit_reg;
    logic tick;

    if (WAIT_W < 1) begin : g_bad_width
        $error("ttsc_wait_timer: WAIT_W must be at least 1");
    end

    assign tick = unit_reg ? half_bit_tick : carrier_tick;

    // prescaler restarts with each wait so the first carrier unit is never short
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ttsc_pkg::wait_idle;
            cnt_reg <= '0;
            pre_reg <= 4'h0;
            unit_reg <= 1'b0;
            elapsed <= 1'b1;
        end
        else if (start)
        begin
            cnt_reg <= count;
            pre_reg <= 4'h0;
            unit_reg <= unit_sel;
            elapsed <= (count == '0);
            state_reg <= (count == '0) ? ttsc_pkg::wait_idle : ttsc_pkg::wait_counting;
        end
        else
        begin
            case (state_reg)
                ttsc_pkg::wait_counting:
                begin
                    if (tick)
                    begin
                        if (unit_reg || pre_reg == `TTSC_CARRIER_PER_UNIT)
                        begin
                            pre_reg <= 4'h0;
                            cnt_reg <= cnt_reg - 1'b1;
                            if (cnt_reg == {{(WAIT_W-1){1'b0}}, 1'b1})
                            begin
                                elapsed <= 1'b1;
                                state_reg <= ttsc_pkg::wait_idle;
                            end
                        end
                        else
                        begin
                            pre_reg <= pre_reg + 4'h1;
                        end
                    end
                end
                default:
                begin
                    elapsed <= 1'b1;
                end
            endcase
        end
    end

    // checking helpers: carrier ticks seen and count latched at the start
    logic [WAIT_W+3:0] obs_ticks;
    logic [WAIT_W-1:0] obs_count;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            obs_ticks <= '0;
            obs_count <= '0;
        end
        else if (start)
        begin
            obs_ticks <= '0;
            obs_count <= count;
        end
        else if (state_reg == ttsc_pkg::wait_counting && carrier_tick)
        begin
            obs_ticks <= obs_ticks + 1'b1;
        end
    end

    property p_carrier_wait;
        @(posedge clk) disable iff (reset)
        $rose(elapsed) && !unit_reg && !$past(start) |-> obs_ticks == {obs_count, 4'h0};
    endproperty
    a_carrier_wait: assert property (p_carrier_wait)
        else $error("carrier wait did not last count times sixteen carrier ticks");

    property p_wait_holds;
        @(posedge clk) disable iff (reset)
        start && count != '0 |=> !elapsed;
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("nonzero wait elapsed immediately after its start event");
endmodule

// File: pkg/ttsc_params.svh
// constants and addresses of the transmit symbol timing block
`ifndef TTSC_PARAMS_SVH
`define TTSC_PARAMS_SVH
`define TTSC_ADDR_MOD_WIDTH 8'h2f
`define TTSC_ADDR_BURST_LEN 8'h30
`define TTSC_ADDR_WAIT_CTRL 8'h31
`define TTSC_RST_MOD_WIDTH 8'h00
`define TTSC_RST_BURST_LEN 8'h00
`define TTSC_RST_WAIT_CTRL 8'hc0
`define TTSC_BURST_MASK 8'h77
`define TTSC_WAIT_START_BIT 7
`define TTSC_WAIT_UNIT_BIT 6
`define TTSC_WAIT_HI_MSB 5
`define TTSC_WAIT_HI_LSB 3
`define TTSC_STOP_MSB 2
`define TTSC_STOP_LSB 0
`define TTSC_SYM1_MSB 6
`define TTSC_SYM1_LSB 4
`define TTSC_SYM0_MSB 2
`define TTSC_SYM0_LSB 0
// 20000 khz system clock, 13560 khz carrier
`define TTSC_CLK_KHZ 16'h4e20
`define TTSC_CARRIER_KHZ 16'h34f8
`define TTSC_CARRIER_PER_UNIT 4'hf
`define TTSC_BURST_LEN0 9'h008
`define TTSC_BURST_LEN1 9'h010
`define TTSC_BURST_LEN2 9'h020
`define TTSC_BURST_LEN3 9'h030
`define TTSC_BURST_LEN4 9'h040
`define TTSC_BURST_LEN5 9'h060
`define TTSC_BURST_LEN6 9'h080
`define TTSC_BURST_LEN7 9'h100
`endif

// File: pkg/ttsc_pkg.sv
// types and decode helpers of the transmit symbol timing block
`include "ttsc_params.svh"
package ttsc_pkg;
    typedef enum logic {wait_idle, wait_counting} ttsc_wait_state_t;

    function automatic logic [8:0] ttsc_burst_bits(input logic [2:0] code);
        case (code)
            3'h0: ttsc_burst_bits = `TTSC_BURST_LEN0;
            3'h1: ttsc_burst_bits = `TTSC_BURST_LEN1;
            3'h2: ttsc_burst_bits = `TTSC_BURST_LEN2;
            3'h3: ttsc_burst_bits = `TTSC_BURST_LEN3;
            3'h4: ttsc_burst_bits = `TTSC_BURST_LEN4;
            3'h5: ttsc_burst_bits = `TTSC_BURST_LEN5;
            3'h6: ttsc_burst_bits = `TTSC_BURST_LEN6;
            default: ttsc_burst_bits = `TTSC_BURST_LEN7;
        endcase
    endfunction
endpackage

// File: testbench/ttsc_card_model.sv
// far-side card model: answers each transmission with a reply frame end
`timescale 1ns/1ps
module ttsc_card_model #(
    parameter int REPLY_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tx_end,
    output logic rx_end
);
    int unsigned cnt_reg;

    // reply ends a fixed time after our frame; a new frame restarts the reply
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_reg <= 0;
            rx_end <= 1'b0;
        end
        else
        begin
            rx_end <= (cnt_reg == 1);
            if (tx_end)
                cnt_reg <= REPLY_CYCLES;
            else if (cnt_reg != 0)
                cnt_reg <= cnt_reg - 1;
        end
    end
endmodule

// File: testbench/tx_symbol_timing_config_bench.sv
// self-checking bench of the transmit symbol timing block
`timescale 1ns/1ps
`include "ttsc_params.svh"
module tx_symbol_timing_config_bench;
    typedef struct packed {logic [7:0] val; logic sym; logic [8:0] bits;} ttsc_burst_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic miller_mode = 1'b1;
    logic type_b_mode = 1'b0;
    logic pulse_start = 1'b0;
    logic bit_end = 1'b0;
    logic bit_tick = 1'b0;
    logic half_bit_tick = 1'b0;
    logic burst_req = 1'b0;
    logic burst_symbol = 1'b0;
    logic burst_level = 1'b0;
    logic tx_req = 1'b0;
    logic tx_end = 1'b0;
    logic [7:0] wait_count_lower = 8'h00;
    logic [1:0] div = 2'h0;
    logic [7:0] reg_rdata;
    logic mod_pulse;
    logic burst_active;
    logic burst_out;
    logic stop_bit_en;
    logic [2:0] guard_count;
    logic tx_start;
    logic wait_elapsed;
    logic rx_end;
    int error_cnt = 0;
    int compares = 0;
    ttsc_burst_row_t rows [12] = '{
        '{8'h70, 1'b0, 9'h008}, '{8'h61, 1'b0, 9'h010}, '{8'h52, 1'b0, 9'h020},
        '{8'h43, 1'b0, 9'h030}, '{8'h34, 1'b0, 9'h040}, '{8'h25, 1'b0, 9'h060},
        '{8'h16, 1'b0, 9'h080}, '{8'h07, 1'b0, 9'h100}, '{8'h07, 1'b1, 9'h008},
        '{8'h35, 1'b1, 9'h030}, '{8'h51, 1'b1, 9'h060}, '{8'h72, 1'b1, 9'h100}};

    always #25 clk = ~clk;

    // bit grid: half bit every 2 clocks, bit every 4
    always @(posedge clk)
    begin
        div <= div + 2'h1;
        half_bit_tick <= div[0];
        bit_tick <= (div == 2'h3);
    end

    ttsc_top #(.WAIT_W(11)) uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .miller_mode(miller_mode), .type_b_mode(type_b_mode),
        .pulse_start(pulse_start), .bit_end(bit_end), .bit_tick(bit_tick),
        .half_bit_tick(half_bit_tick), .burst_req(burst_req), .burst_symbol(burst_symbol),
        .burst_level(burst_level), .tx_req(tx_req), .tx_end(tx_end), .rx_end(rx_end),
        .wait_count_lower(wait_count_lower), .mod_pulse(mod_pulse),
        .burst_active(burst_active), .burst_out(burst_out), .stop_bit_en(stop_bit_en),
        .guard_count(guard_count), .tx_start(tx_start), .wait_elapsed(wait_elapsed));

    ttsc_card_model #(.REPLY_CYCLES(20)) card (.clk(clk), .reset(reset), .tx_end(tx_end),
        .rx_end(rx_end));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input int tol);
        compares++;
        if (got > exp + tol || got < exp - tol)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask

    task automatic mod_len(input logic [7:0] w, output int len);
        wr(`TTSC_ADDR_MOD_WIDTH, w);
        @(posedge clk);
        pulse_start <= 1'b1;
        @(posedge clk);
        pulse_start <= 1'b0;
        len = 0;
        repeat (120)
        begin
            @(negedge clk);
            if (mod_pulse === 1'b1)
                len++;
        end
    endtask

    // guard wait: counts half-bit ticks or clocks while the wait is running
    task automatic wait_run(input logic [7:0] ctrl, input logic [7:0] lower, input int exp,
        input int tol);
        int n;
        logic started;
        n = 0;
        started = 1'b0;
        wr(`TTSC_ADDR_WAIT_CTRL, ctrl);
        @(posedge clk);
        wait_count_lower <= lower;
        tx_end <= 1'b1;
        tx_req <= ~ctrl[7];
        @(posedge clk);
        tx_end <= 1'b0;
        tx_req <= 1'b0;
        for (int i = 0; i < 2200; i++)
        begin
            @(negedge clk);
            if (i == 3)
                chk(wait_elapsed, ctrl[7]);
            if (wait_elapsed !== 1'b1)
            begin
                n = n + (ctrl[6] ? int'(half_bit_tick) : 1);
                chk(tx_start, 1'b0);
            end
            else if (tx_start === 1'b1)
                started = 1'b1;
        end
        near(n, exp, tol);
        chk(started, !ctrl[7]);
        $display("wait test ctrl=%h done", ctrl);
    endtask

    task automatic close_out;
        $display("compares=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n;
        int k;
        int len;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // burst length table, both symbols
        foreach (rows[r])
        begin
            wr(`TTSC_ADDR_BURST_LEN, rows[r].val);
            @(posedge clk);
            burst_req <= 1'b1;
            burst_symbol <= rows[r].sym;
            burst_level <= ~rows[r].sym;
            @(posedge clk);
            burst_req <= 1'b0;
            n = 0;
            k = 0;
            do
            begin
                @(negedge clk);
                if (k == 0)
                    chk(burst_out, !rows[r].sym);
                if (burst_active === 1'b1 && bit_tick === 1'b1)
                    n++;
                k++;
            end
            while (burst_active === 1'b1 && k < 1100);
            chk(16'(n), 16'(rows[r].bits));
            chk(burst_out, 1'b0);
        end
        $display("burst table done");
        // reset values, also after a second reset in mid-run
        wr(`TTSC_ADDR_WAIT_CTRL, 8'h00);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(wait_elapsed, 1'b1);
        rd(`TTSC_ADDR_WAIT_CTRL, 8'hc0);
        rd(`TTSC_ADDR_MOD_WIDTH, 8'h00);
        rd(`TTSC_ADDR_BURST_LEN, 8'h00);
        $display("reset test done");
        // register access, masked and unmapped places
        wr(`TTSC_ADDR_MOD_WIDTH, 8'ha5);
        rd(`TTSC_ADDR_MOD_WIDTH, 8'ha5);
        wr(`TTSC_ADDR_BURST_LEN, 8'hff);
        rd(`TTSC_ADDR_BURST_LEN, 8'h77);
        wr(`TTSC_ADDR_WAIT_CTRL, 8'h3c);
        rd(`TTSC_ADDR_WAIT_CTRL, 8'h3c);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        $display("register test done");
        // stop bit and guard decode, type B only
        @(posedge clk);
        type_b_mode <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            wr(`TTSC_ADDR_WAIT_CTRL, 8'(c));
            repeat (2) @(negedge clk);
            chk(stop_bit_en, 16'(c != 0));
            chk(guard_count, 16'(c == 0 ? 0 : c - 1));
        end
        @(posedge clk);
        type_b_mode <= 1'b0;
        repeat (2) @(negedge clk);
        chk(stop_bit_en, 1'b0);
        chk(guard_count, 3'h0);
        $display("stop test done");
        // modulation pulse width in carrier clocks
        mod_len(8'h00, len);
        near(len, 1, 2);
        mod_len(8'h07, len);
        near(len, 12, 2);
        mod_len(8'h28, len);
        near(len, 60, 2);
        @(posedge clk);
        miller_mode <= 1'b0;
        mod_len(8'h07, len);
        near(len, 0, 0);
        @(posedge clk);
        miller_mode <= 1'b1;
        // long pulse cut by the end of its bit
        wr(`TTSC_ADDR_MOD_WIDTH, 8'hff);
        @(posedge clk);
        pulse_start <= 1'b1;
        @(posedge clk);
        pulse_start <= 1'b0;
        @(negedge clk);
        chk(mod_pulse, 1'b1);
        repeat (4) @(posedge clk);
        bit_end <= 1'b1;
        @(posedge clk);
        bit_end <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(mod_pulse, 1'b0);
        $display("pulse test done");
        // guard wait: units, upper bits, start event
        wait_run(8'h40, 8'h05, 5, 0);
        wait_run(8'h48, 8'h02, 258, 0);
        wait_run(8'h60, 8'h00, 1024, 0);
        wait_run(8'h00, 8'h02, 47, 2);
        wait_run(8'hc0, 8'h04, 4, 0);
        close_out();
    end
endmodule
